// *** src/fspe_top.sv ***
// Overview of operation
// - Command bits 1:0 pick protect, sector erase, bulk erase or nothing.
// - Protect writes the top/bottom and block-protect bits of the sector field into the flash status register.
// - Sector erase erases the one sector indexed by command bits 23:8.
// - Bulk erase clears the whole array so every bit reads one.
// - Protect uses bit 12 as top/bottom and bits 11:8 as block protect.
// - One sector per erase, each sector spanning 65536 byte addresses.
// - Write to a protected sector is cancelled and sets status bit 1.
// - Erase of a protected sector is cancelled and sets status bit 0.
// - Interrupt only for a set flag whose mask bit is one.
//
// Design decisions made here: the address map and strobed register access.
`timescale 1ns/100ps
module fspe_top #(
  parameter int NUM_SECTORS = 2048,
  parameter int SECT_W      = 11
) (
  input  wire logic        CORE_CLK,
  input  wire logic        RSTN,
  input  wire logic [2:0]  ADDR,
  input  wire logic [31:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [31:0] RDATA,
  output logic             IRQ,
  input  wire logic        WR_CHECK_REQ,
  input  wire logic [10:0] WR_CHECK_SECTOR,
  output logic             WR_CHECK_OK,
  output logic             WR_CHECK_DENY,
  output logic             FLASH_DCLK,
  output logic             FLASH_NCS,
  output logic             FLASH_DOUT,
  input  wire logic        FLASH_DIN
);

  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_CHECK = 5'b00010,
    ST_WREN  = 5'b00100,
    ST_OPER  = 5'b01000,
    ST_POLL  = 5'b10000
  } fspe_state_e;

  localparam logic [11:0] NSEC = 12'(NUM_SECTORS);

  fspe_state_e           state;
  fspe_pkg::fspe_cmd_s   cmd_pend;
  logic                  cmd_valid;
  fspe_pkg::fspe_cmd_s   cur;
  fspe_pkg::fspe_frame_s frame;
  logic                  spi_start;
  logic                  spi_active;
  logic                  spi_done;
  logic [7:0]            spi_rx;
  logic                  tick;
  logic                  din_meta;
  logic                  din_sync;
  logic [1:0]            viol_status;
  logic [1:0]            viol_mask;
  logic                  erase_viol_set;
  logic                  shadow_tbs;
  logic [3:0]            shadow_bp;
  logic                  cmd_wr;
  logic                  cmd_take;
  logic                  cur_prot;
  logic                  wr_prot;
  logic [1:0]            viol_set;
  logic [1:0]            viol_clr;
  logic [31:0]           next_rdata;

  // Flash data input crosses in from the pin
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      din_meta <= 1'b0;
      din_sync <= 1'b0;
    end else begin
      din_meta <= FLASH_DIN;
      din_sync <= din_meta;
    end
  end

  // Serial clock rate enable
  fspe_tick_gen #(
    .HALF_CYC (fspe_pkg::SCK_HALF_CYC)
  ) u_tick (
    .clk   (CORE_CLK),
    .rst_n (RSTN),
    .en    (spi_active),
    .tick  (tick)
  );

  // Serial frame engine drives the flash pins from its own flops
  fspe_spi_shift u_shift (
    .clk     (CORE_CLK),
    .rst_n   (RSTN),
    .tick    (tick),
    .start   (spi_start),
    .frame   (frame),
    .din     (din_sync),
    .active  (spi_active),
    .done    (spi_done),
    .rx_byte (spi_rx),
    .sclk    (FLASH_DCLK),
    .ncs     (FLASH_NCS),
    .dout    (FLASH_DOUT)
  );

  // Command decode at the register port
  // nonzero launches one
  assign cmd_wr = WR && (ADDR == fspe_pkg::ADR_MEM_OP)
                  && (WDATA[fspe_pkg::OP_MSB:fspe_pkg::OP_LSB] != fspe_pkg::OP_NONE)
                  && !cmd_valid;
  assign cmd_take = (state == ST_IDLE) && cmd_valid;

  // One pending command slot; a write that finds it full is dropped
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      cmd_valid       <= 1'b0;
      cmd_pend.op     <= fspe_pkg::OP_NONE;
      cmd_pend.sector <= fspe_pkg::SECT_RST;
    end else if (cmd_wr) begin
      cmd_valid       <= 1'b1;
      cmd_pend.op     <= fspe_pkg::fspe_op_e'(WDATA[fspe_pkg::OP_MSB:fspe_pkg::OP_LSB]);
      cmd_pend.sector <= WDATA[fspe_pkg::SECT_MSB:fspe_pkg::SECT_LSB];
    end else if (cmd_take) begin
      cmd_valid <= 1'b0;
    end
  end

  // Protection lookup against the bits last written to the flash
  // protected erase check
  always_comb begin
    cur_prot = 1'b0;
    if (cur.op == fspe_pkg::OP_ERASE) begin
      cur_prot = fspe_pkg::fspe_is_protected(shadow_tbs, shadow_bp,
                                             cur.sector[10:0], NSEC)
                 || (cur.sector >= 16'(NUM_SECTORS));
    end else if (cur.op == fspe_pkg::OP_BULK) begin
      // Bulk erase would touch every protected sector
      cur_prot = (shadow_bp != 4'h0);
    end
  end

  assign wr_prot = fspe_pkg::fspe_is_protected(shadow_tbs, shadow_bp,
                                               WR_CHECK_SECTOR, NSEC);

  // Operation sequencer: write enable, operation, then poll until done
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      state          <= ST_IDLE;
      cur.op         <= fspe_pkg::OP_NONE;
      cur.sector     <= fspe_pkg::SECT_RST;
      spi_start      <= 1'b0;
      frame.tx       <= 40'h00_0000_0000;
      frame.nbytes   <= 3'h0;
      erase_viol_set <= 1'b0;
    end else begin
      spi_start      <= 1'b0;
      erase_viol_set <= 1'b0;
      unique case (state)
        ST_IDLE: begin
          if (cmd_take) begin
            cur   <= cmd_pend;
            state <= ST_CHECK;
          end
        end
        ST_CHECK: begin
          if (cur_prot) begin
            erase_viol_set <= 1'b1;
            state          <= ST_IDLE;
          end else begin
            frame.tx     <= {fspe_pkg::FC_WREN, 32'h0000_0000};
            frame.nbytes <= 3'h1;
            spi_start    <= 1'b1;
            state        <= ST_WREN;
          end
        end
        ST_WREN: begin
          if (spi_done) begin
            spi_start <= 1'b1;
            state     <= ST_OPER;
            unique case (cur.op)
              fspe_pkg::OP_PROTECT: begin
                frame.tx     <= {fspe_pkg::FC_WRSR, prot_status(cur.sector), 24'h00_0000};
                frame.nbytes <= 3'h2;
              end
              fspe_pkg::OP_ERASE: begin
                frame.tx     <= {fspe_pkg::FC_SE, sector_addr(cur.sector)};
                frame.nbytes <= 3'h5;
              end
              fspe_pkg::OP_BULK: begin
                frame.tx     <= {fspe_pkg::FC_BE, 32'h0000_0000};
                frame.nbytes <= 3'h1;
              end
              fspe_pkg::OP_NONE: begin
                frame.tx     <= 40'h00_0000_0000;
                frame.nbytes <= 3'h0;
                spi_start    <= 1'b0;
                state        <= ST_IDLE;
              end
            endcase
          end
        end
        ST_OPER: begin
          if (spi_done) begin
            frame.tx     <= {fspe_pkg::FC_RDSR, 32'h0000_0000};
            frame.nbytes <= 3'h2;
            spi_start    <= 1'b1;
            state        <= ST_POLL;
          end
        end
        ST_POLL: begin
          // Flash keeps its busy bit set until the operation ends
          if (spi_done) begin
            if (spi_rx[fspe_pkg::SR_WIP]) begin
              spi_start <= 1'b1;
            end else begin
              state <= ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  // Status byte holding the five protection bits
  // five bits used
  function automatic logic [7:0] prot_status(input logic [15:0] sv);
    logic [7:0] b;
    b = 8'h00;
    b[fspe_pkg::SR_TB_BIT] = sv[fspe_pkg::TBS_BIT - fspe_pkg::SECT_LSB];
    b[fspe_pkg::SR_BP_LSB +: 4] = sv[3:0];
    prot_status = b;
  endfunction : prot_status

  // Byte address of a sector's first location
  function automatic logic [31:0] sector_addr(input logic [15:0] sv);
    sector_addr = {sv, 16'h0000} >> (32 - fspe_pkg::SECT_SHIFT - 16);
  endfunction : sector_addr

  // Shadow of the protection bits, updated once the flash took them
  // keep protect bits
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      shadow_tbs <= 1'b0;
      shadow_bp  <= 4'h0;
    end else if ((state == ST_OPER) && spi_done && (cur.op == fspe_pkg::OP_PROTECT)) begin
      shadow_tbs <= cur.sector[fspe_pkg::TBS_BIT - fspe_pkg::SECT_LSB];
      shadow_bp  <= cur.sector[fspe_pkg::BP_MSB - fspe_pkg::SECT_LSB:0];
    end
  end

  // Answer to the data path write check, one cycle after the request
  // cancel write
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      WR_CHECK_OK   <= 1'b0;
      WR_CHECK_DENY <= 1'b0;
    end else begin
      WR_CHECK_OK   <= WR_CHECK_REQ && !wr_prot;
      WR_CHECK_DENY <= WR_CHECK_REQ && wr_prot;
    end
  end

  // Sticky violation flags; a set in the clearing cycle survives
  always_comb begin
    viol_set = 2'b00;
    viol_set[fspe_pkg::VIOL_ERASE_BIT] = erase_viol_set;
    viol_set[fspe_pkg::VIOL_WRITE_BIT] = WR_CHECK_REQ && wr_prot;
    viol_clr = 2'b00;
    if (WR && (ADDR == fspe_pkg::ADR_VIOL_STATUS)) begin
      viol_clr = WDATA[1:0];
    end
  end

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      viol_status <= fspe_pkg::VIOL_RST;
    end else begin
      viol_status <= (viol_status & ~viol_clr) | viol_set;
    end
  end

  // Interrupt mask register
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      viol_mask <= fspe_pkg::MASK_RST;
    end else if (WR && (ADDR == fspe_pkg::ADR_VIOL_MASK)) begin
      viol_mask <= WDATA[1:0];
    end
  end

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(viol_status & viol_mask);
    end
  end

  // Read mux; command register is write only and reads zero
  always_comb begin
    next_rdata = fspe_pkg::RDATA_RST;
    if (RD) begin
      unique case (ADDR)
        fspe_pkg::ADR_VIOL_STATUS: next_rdata = {30'h0000_0000, viol_status};
        fspe_pkg::ADR_VIOL_MASK:   next_rdata = {30'h0000_0000, viol_mask};
        fspe_pkg::ADR_CTRL_STATE: begin
          next_rdata[fspe_pkg::CS_BUSY_BIT]      = (state != ST_IDLE);
          next_rdata[fspe_pkg::CS_PEND_BIT]      = cmd_valid;
          next_rdata[fspe_pkg::CS_BP_LSB +: 4]   = shadow_bp;
          next_rdata[fspe_pkg::CS_TBS_BIT]       = shadow_tbs;
        end
        default:                   next_rdata = fspe_pkg::RDATA_RST;
      endcase
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      RDATA <= fspe_pkg::RDATA_RST;
    end else begin
      RDATA <= next_rdata;
    end
  end

endmodule : fspe_top

// *** inc/fspe_pkg.sv ***
package fspe_pkg;

  // Register indices on the plain register port
  localparam logic [2:0] ADR_MEM_OP      = 3'h3;
  localparam logic [2:0] ADR_VIOL_STATUS = 3'h4;
  localparam logic [2:0] ADR_VIOL_MASK   = 3'h5;
  localparam logic [2:0] ADR_CTRL_STATE  = 3'h7;

  // Command register fields
  localparam int OP_LSB   = 0;
  localparam int OP_MSB   = 1;
  localparam int SECT_LSB = 8;
  localparam int SECT_MSB = 23;
  localparam int TBS_BIT  = 12;
  localparam int BP_LSB   = 8;
  localparam int BP_MSB   = 11;

  // Violation status and mask bit positions
  localparam int VIOL_ERASE_BIT = 0;
  localparam int VIOL_WRITE_BIT = 1;

  // Controller state register fields
  localparam int CS_BUSY_BIT = 0;
  localparam int CS_PEND_BIT = 1;
  localparam int CS_BP_LSB   = 4;
  localparam int CS_TBS_BIT  = 8;

  // Reset values
  localparam logic [1:0]  VIOL_RST   = 2'h0;
  localparam logic [1:0]  MASK_RST   = 2'h0;
  localparam logic [15:0] SECT_RST   = 16'h0000;
  localparam logic [31:0] RDATA_RST  = 32'h0000_0000;

  // Serial flash instruction codes and status layout
  localparam logic [7:0] FC_WREN   = 8'h06;
  localparam logic [7:0] FC_WRSR   = 8'h01;
  localparam logic [7:0] FC_RDSR   = 8'h05;
  localparam logic [7:0] FC_SE     = 8'hdc;
  localparam logic [7:0] FC_BE     = 8'hc7;
  localparam int         SR_WIP    = 0;
  localparam int         SR_BP_LSB = 2;
  localparam int         SR_TB_BIT = 6;
  localparam int         SECT_SHIFT = 16;  // 65536 bytes per sector

  // Serial clock half period
  localparam int CORE_PERIOD_NS = 10;
  localparam int SCK_HALF_NS    = 40;
  localparam int SCK_HALF_CYC   = (SCK_HALF_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;

  typedef enum logic [1:0] {
    OP_NONE    = 2'b00,
    OP_BULK    = 2'b01,
    OP_ERASE   = 2'b10,
    OP_PROTECT = 2'b11
  } fspe_op_e;

  typedef struct packed {
    fspe_op_e    op;
    logic [15:0] sector;
  } fspe_cmd_s;

  typedef struct packed {
    logic [39:0] tx;
    logic [2:0]  nbytes;
  } fspe_frame_s;

  // Sector protected by top/bottom plus four block-protect bits
  function automatic logic fspe_is_protected(input logic        tbs,
                                             input logic [3:0]  bp,
                                             input logic [10:0] sec,
                                             input logic [11:0] nsec);
    logic [11:0] cnt;
    cnt = 12'h000;
    if (bp != 4'h0) begin
      if (bp > 4'hb) begin
        cnt = nsec;
      end else begin
        cnt = 12'h001 << (bp - 4'h1);
      end
      if (cnt > nsec) begin
        cnt = nsec;
      end
    end
    if (tbs) begin
      fspe_is_protected = ({1'b0, sec} < cnt);
    end else begin
      fspe_is_protected = (cnt != 12'h000) && ({1'b0, sec} >= (nsec - cnt));
    end
  endfunction : fspe_is_protected

endpackage : fspe_pkg

// *** src/fspe_tick_gen.sv ***
`timescale 1ns/100ps
module fspe_tick_gen #(
  parameter int HALF_CYC = 4
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic en,
  output logic      tick
);

  logic [7:0] cnt;

  // Divider restarts whenever the serial engine is idle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt  <= 8'h00;
      tick <= 1'b0;
    end else if (!en) begin
      cnt  <= 8'h00;
      tick <= 1'b0;
    end else if (cnt == 8'(HALF_CYC - 1)) begin
      cnt  <= 8'h00;
      tick <= 1'b1;
    end else begin
      cnt  <= cnt + 8'h01;
      tick <= 1'b0;
    end
  end

endmodule : fspe_tick_gen

// *** src/fspe_spi_shift.sv ***
`timescale 1ns/100ps
module fspe_spi_shift (
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic                tick,
  input  wire logic                start,
  input  fspe_pkg::fspe_frame_s    frame,
  input  wire logic                din,
  output logic                     active,
  output logic                     done,
  output logic [7:0]               rx_byte,
  output logic                     sclk,
  output logic                     ncs,
  output logic                     dout
);

  logic [39:0] sr;
  logic [5:0]  bits_left;

  // Mode 0 framing: data set up on the low phase, sampled on the rising edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sr        <= 40'h00_0000_0000;
      bits_left <= 6'h00;
      active    <= 1'b0;
      done      <= 1'b0;
      rx_byte   <= 8'h00;
      sclk      <= 1'b0;
      ncs       <= 1'b1;
      dout      <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start && !active) begin
        sr        <= frame.tx;
        bits_left <= {frame.nbytes, 3'b000};
        active    <= 1'b1;
        ncs       <= 1'b0;
        dout      <= frame.tx[39];
      end else if (active && tick) begin
        if (!sclk) begin
          sclk    <= 1'b1;
          rx_byte <= {rx_byte[6:0], din};
        end else begin
          sclk      <= 1'b0;
          sr        <= {sr[38:0], 1'b0};
          dout      <= sr[38];
          bits_left <= bits_left - 6'h01;
          // Last bit out: close the frame so the flash acts on it
          if (bits_left == 6'h01) begin
            active <= 1'b0;
            ncs    <= 1'b1;
            done   <= 1'b1;
          end
        end
      end
    end
  end

endmodule : fspe_spi_shift

// *** testbench/fspe_top_properties.sv ***
`timescale 1ns/100ps
module fspe_top_props #(
  parameter int NUM_SECTORS = 2048
) (
  input wire logic        CORE_CLK,
  input wire logic        RSTN,
  input wire logic [2:0]  ADDR,
  input wire logic [31:0] WDATA,
  input wire logic        WR,
  input wire logic        RD,
  input wire logic [31:0] RDATA,
  input wire logic        IRQ,
  input wire logic        WR_CHECK_REQ,
  input wire logic [10:0] WR_CHECK_SECTOR,
  input wire logic        WR_CHECK_OK,
  input wire logic        WR_CHECK_DENY,
  input wire logic        FLASH_DCLK,
  input wire logic        FLASH_NCS,
  input wire logic        FLASH_DOUT,
  input wire logic        FLASH_DIN
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RSTN);
  logic [1:0] mask_m;
  // Mirror of the mask register, since the checker sees only ports
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      mask_m <= fspe_pkg::MASK_RST;
    end else if (WR && ADDR == fspe_pkg::ADR_VIOL_MASK) begin
      mask_m <= WDATA[1:0];
    end
  end
  a_irq_needs_mask: assert property (IRQ |-> $past(mask_m) != 2'h0)
    else $error("interrupt high with every mask bit clear");
  a_deny_raises_irq: assert property (WR_CHECK_DENY && mask_m[1] |=> IRQ)
    else $error("denied write did not raise the interrupt");
  a_check_answer: assert property (WR_CHECK_REQ |=> WR_CHECK_OK != WR_CHECK_DENY)
    else $error("write check not answered by exactly one pulse");
  a_check_unasked: assert property (!$past(WR_CHECK_REQ) |-> !(WR_CHECK_OK || WR_CHECK_DENY))
    else $error("write check answer without a request");
  a_mask_readback: assert property ($past(RD) && $past(ADDR) == fspe_pkg::ADR_VIOL_MASK
    |-> RDATA == {30'h0000_0000, $past(mask_m)})
    else $error("mask read data differs from the written mask");
  a_status_width: assert property ($past(RD) && $past(ADDR) == fspe_pkg::ADR_VIOL_STATUS
    |-> RDATA[31:2] == 30'h0000_0000)
    else $error("status read has upper bits set");
  a_rdata_idle: assert property (!$past(RD) |-> RDATA == 32'h0000_0000)
    else $error("read data present without a read");
  a_dclk_idle: assert property (FLASH_NCS |-> !FLASH_DCLK)
    else $error("serial clock high while flash is deselected");
  a_dclk_half: assert property ($rose(FLASH_DCLK) |-> FLASH_DCLK [*4] ##1 !FLASH_DCLK)
    else $error("serial clock high phase is not four cycles");
  a_dout_hold: assert property (FLASH_DCLK && $past(FLASH_DCLK) |-> $stable(FLASH_DOUT))
    else $error("serial data changed while the clock was high");
  c_deny: cover property (WR_CHECK_DENY);
  c_frame: cover property ($fell(FLASH_NCS));
  c_irq: cover property ($rose(IRQ));
endmodule : fspe_top_props
bind fspe_top fspe_top_props #(.NUM_SECTORS(NUM_SECTORS)) u_props (
  .CORE_CLK(CORE_CLK), .RSTN(RSTN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
  .RDATA(RDATA), .IRQ(IRQ), .WR_CHECK_REQ(WR_CHECK_REQ), .WR_CHECK_SECTOR(WR_CHECK_SECTOR),
  .WR_CHECK_OK(WR_CHECK_OK), .WR_CHECK_DENY(WR_CHECK_DENY), .FLASH_DCLK(FLASH_DCLK),
  .FLASH_NCS(FLASH_NCS), .FLASH_DOUT(FLASH_DOUT), .FLASH_DIN(FLASH_DIN));

// *** testbench/fspe_flash_model.sv ***
`timescale 1ns/100ps
module fspe_flash_model (
  input  wire logic sclk,
  input  wire logic cs_n,
  input  wire logic mosi,
  output logic      miso
);
  logic [39:0] sh = '0;
  logic [7:0]  cur_op = 8'h00;
  logic [7:0]  sr = 8'h00;
  logic [7:0]  st;
  logic [7:0]  last_op = 8'h00;
  logic [31:0] last_addr = 32'h0000_0000;
  logic        wel = 1'b0;
  int          nbits = 0;
  int          ops = 0;
  int          busy_left = 0;
  initial miso = 1'b0;
  // Bits are taken at the rising serial clock, MSB first
  always @(posedge sclk) begin
    if (!cs_n) begin
      sh <= {sh[38:0], mosi};
      nbits <= nbits + 1;
    end
  end
  always @(negedge cs_n) nbits = 0;
  // Status byte after a status read; otherwise the line keeps changing
  always @(negedge sclk) begin
    st = {sr[7:1], busy_left != 0};
    if (nbits == 8) cur_op = sh[7:0];
    if (!cs_n && nbits >= 8 && nbits < 16 && cur_op == fspe_pkg::FC_RDSR) miso = st[15 - nbits];
    else miso = ~miso;
  end
  always #7 if (cs_n) miso = ~miso;
  // An operation without a prior write enable is ignored, as real parts do
  always @(posedge cs_n) begin
    if (nbits == 8 && sh[7:0] == fspe_pkg::FC_WREN) begin
      wel = 1'b1;
    end else if (nbits == 16 && sh[15:8] == fspe_pkg::FC_RDSR) begin
      if (busy_left > 0) busy_left--;
    end else if (wel && (nbits == 8 || nbits == 16 || nbits == 40)) begin
      last_op = (nbits == 8) ? sh[7:0] : (nbits == 16) ? sh[15:8] : sh[39:32];
      if (nbits == 16) sr = sh[7:0];
      if (nbits == 40) last_addr = sh[31:0];
      ops++;
      wel = 1'b0;
      busy_left = 2;
    end
  end
endmodule : fspe_flash_model

// *** testbench/fspe_top_tb.sv ***
`timescale 1ns/100ps
module fspe_top_tb;
  localparam int NSEC = 32;
  localparam int PROT = 1 << (3 - 1);
  logic        CORE_CLK = 1'b0;
  logic        RSTN = 1'b0;
  logic [2:0]  ADDR = 3'h0;
  logic [31:0] WDATA = 32'h0000_0000;
  logic        WR = 1'b0;
  logic        RD = 1'b0;
  logic        WR_CHECK_REQ = 1'b0;
  logic [10:0] WR_CHECK_SECTOR = 11'h000;
  logic [31:0] RDATA;
  logic        IRQ, WR_CHECK_OK, WR_CHECK_DENY, FLASH_DCLK, FLASH_NCS, FLASH_DOUT, FLASH_DIN;
  logic        rd_chk = 1'b0;
  logic        rd_seen = 1'b0;
  logic        ck_seen = 1'b0;
  logic [31:0] exp_rd[$];
  logic [1:0]  exp_ck[$];
  logic [31:0] cmds[3] = '{32'h0000_0202, 32'h0000_2002, 32'h0000_0001};
  int          bad_count = 0;
  int          compares = 0;
  int          cycles = 0;
  int          seed = 32'ha52d;
  int          sec, n, ops0;
  always #5 CORE_CLK = ~CORE_CLK;
  fspe_top #(.NUM_SECTORS(NSEC), .SECT_W(5)) u_dut (
    .CORE_CLK(CORE_CLK), .RSTN(RSTN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .IRQ(IRQ), .WR_CHECK_REQ(WR_CHECK_REQ), .WR_CHECK_SECTOR(WR_CHECK_SECTOR),
    .WR_CHECK_OK(WR_CHECK_OK), .WR_CHECK_DENY(WR_CHECK_DENY), .FLASH_DCLK(FLASH_DCLK),
    .FLASH_NCS(FLASH_NCS), .FLASH_DOUT(FLASH_DOUT), .FLASH_DIN(FLASH_DIN));
  fspe_flash_model u_flash (.sclk(FLASH_DCLK), .cs_n(FLASH_NCS), .mosi(FLASH_DOUT),
    .miso(FLASH_DIN));
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    compares++;
    if (seen !== want) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check
  task automatic end_of_test();
    $display("mismatches %0d of %0d compares", bad_count, compares);
    if (bad_count == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_of_test
  // Hang guard, far above the longest expected run
  always @(posedge CORE_CLK) begin
    cycles++;
    if (cycles == 60000) begin
      bad_count++;
      end_of_test();
    end
  end
  // Watcher: results are matched to notes in issue order
  always @(posedge CORE_CLK) begin
    rd_seen <= RD && rd_chk;
    ck_seen <= WR_CHECK_REQ;
  end
  always @(negedge CORE_CLK) begin
    if (rd_seen) check(RDATA, exp_rd.pop_front());
    if (ck_seen) check({30'h0, WR_CHECK_DENY, WR_CHECK_OK}, {30'h0, exp_ck.pop_front()});
  end
  // Bus cycles: strobes are lowered by the next call, so none is set twice at once
  task automatic reg_wr(input logic [2:0] a, input logic [31:0] d);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    RD <= 1'b0;
    @(posedge CORE_CLK);
  endtask : reg_wr
  task automatic reg_rd(input logic [2:0] a, input logic [31:0] e, input logic chk);
    ADDR <= a;
    WR <= 1'b0;
    RD <= 1'b1;
    // A check request left up by wchk would be answered once more here
    WR_CHECK_REQ <= 1'b0;
    rd_chk <= chk;
    if (chk) exp_rd.push_back(e);
    @(posedge CORE_CLK);
  endtask : reg_rd
  task automatic idle();
    WR <= 1'b0;
    RD <= 1'b0;
    WR_CHECK_REQ <= 1'b0;
    @(posedge CORE_CLK);
  endtask : idle
  task automatic wchk(input logic [10:0] s, input logic deny);
    WR_CHECK_REQ <= 1'b1;
    WR_CHECK_SECTOR <= s;
    exp_ck.push_back(deny ? 2'b10 : 2'b01);
    @(posedge CORE_CLK);
  endtask : wchk
  task automatic look(input logic e);
    idle();
    idle();
    @(negedge CORE_CLK);
    check(32'(IRQ), 32'(e));
    @(posedge CORE_CLK);
  endtask : look
  // Polls the busy and pending bits until both drop
  task automatic wait_done();
    logic [1:0] st;
    for (n = 0; n < 2000; n++) begin
      reg_rd(fspe_pkg::ADR_CTRL_STATE, 32'h0000_0000, 1'b0);
      RD <= 1'b0;
      @(negedge CORE_CLK);
      st = RDATA[1:0];
      @(posedge CORE_CLK);
      if (st === 2'b00) break;
    end
    // Poll limit running out leaves the busy or pending bit set
    check(32'(st), 32'h0000_0000);
  endtask : wait_done
  initial begin
    repeat (5) @(posedge CORE_CLK);
    RSTN <= 1'b1;
    @(posedge CORE_CLK);
    // Reset values and an unmapped index read as zero
    reg_rd(fspe_pkg::ADR_VIOL_STATUS, 32'h0000_0000, 1'b1);
    reg_rd(fspe_pkg::ADR_VIOL_MASK, 32'h0000_0000, 1'b1);
    reg_rd(3'h6, 32'h0000_0000, 1'b1);
    // reserved sector bits zero; bottom four sectors protected
    reg_wr(fspe_pkg::ADR_MEM_OP, 32'h0000_1303);
    wait_done();
    check(32'(u_flash.last_op), 32'(fspe_pkg::FC_WRSR));
    check(32'(u_flash.sr), 32'h0000_004c);
    // Edges of the protected range, then random sectors back to back
    wchk(11'h000, 1'b1);
    wchk(11'h003, 1'b1);
    wchk(11'h004, 1'b0);
    wchk(11'h01f, 1'b0);
    for (int i = 0; i < 12; i++) begin
      sec = $unsigned($random(seed)) % NSEC;
      wchk(sec[10:0], sec < PROT);
    end
    reg_rd(fspe_pkg::ADR_VIOL_STATUS, 32'h0000_0002, 1'b1);
    // Shadow of the protect bits: top/bottom in bit 8, block protect in 7:4
    reg_rd(fspe_pkg::ADR_CTRL_STATE, 32'h0000_0130, 1'b1);
    look(1'b0);
    reg_wr(fspe_pkg::ADR_VIOL_MASK, 32'h0000_0002);
    look(1'b1);
    reg_wr(fspe_pkg::ADR_VIOL_STATUS, 32'h0000_0002);
    look(1'b0);
    reg_wr(fspe_pkg::ADR_VIOL_MASK, 32'h0000_0003);
    // Protected erase, index past the part, bulk while protected: all cancelled
    foreach (cmds[i]) begin
      ops0 = u_flash.ops;
      reg_wr(fspe_pkg::ADR_MEM_OP, cmds[i]);
      wait_done();
      check(32'(u_flash.ops), 32'(ops0));
      reg_rd(fspe_pkg::ADR_VIOL_STATUS, 32'h0000_0001, 1'b1);
      look(1'b1);
      reg_wr(fspe_pkg::ADR_VIOL_STATUS, 32'h0000_0001);
      look(1'b0);
    end
    // legal index for the smallest part
    sec = PROT + $unsigned($random(seed)) % (NSEC - PROT);
    ops0 = u_flash.ops;
    reg_wr(fspe_pkg::ADR_MEM_OP, {8'h00, sec[15:0], 8'h02});
    wait_done();
    check(32'(u_flash.last_op), 32'(fspe_pkg::FC_SE));
    check(u_flash.last_addr, sec << 16);
    check(32'(u_flash.ops), 32'(ops0 + 1));
    reg_wr(fspe_pkg::ADR_MEM_OP, 32'h0000_0900);
    repeat (40) idle();
    check(32'(u_flash.ops), 32'(ops0 + 1));
    // attached part is single die; unprotect first, then bulk erase
    reg_wr(fspe_pkg::ADR_MEM_OP, 32'h0000_0003);
    wait_done();
    check(32'(u_flash.sr), 32'h0000_0000);
    reg_wr(fspe_pkg::ADR_MEM_OP, 32'h0000_0001);
    wait_done();
    check(32'(u_flash.last_op), 32'(fspe_pkg::FC_BE));
    check(32'(u_flash.ops), 32'(ops0 + 3));
    idle();
    end_of_test();
  end
endmodule : fspe_top_tb
